// ---- rtl/tcc_defs.svh ----
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// Register byte offsets inside one 0x40 channel window
`define TCC_OFF_CCR      6'h00
`define TCC_OFF_CMR      6'h04
`define TCC_OFF_CVR      6'h10
`define TCC_OFF_RA       6'h14
`define TCC_OFF_RB       6'h18
`define TCC_OFF_RC       6'h1c
`define TCC_OFF_SR       6'h20
// Block registers sit in the fourth window (0xc0, 0xc4)
`define TCC_BLK_CH       2'h3
`define TCC_OFF_BCR      6'h00
`define TCC_OFF_BMR      6'h04

`define TCC_CMR_RST      32'h0000_0000
`define TCC_BMR_RST      6'h00

// Channel mode fields (low bit position)
`define TCC_CMR_SRC      0
`define TCC_CMR_CLOCK_INVERT     3
`define TCC_CMR_BURST    4
`define TCC_CMR_STOP     6
`define TCC_CMR_DIS      7
`define TCC_CMR_EDGE     8
`define TCC_CMR_TRIGGER_INPUT_SELECT   10
`define TCC_CMR_EVSEL    10
`define TCC_CMR_EVENT_TRIGGER_ENABLE   12
`define TCC_CMR_COMPARE_C_TRIGGER_ENABLE   14
`define TCC_CMR_WAVE     15
`define TCC_CMR_LDA      16
`define TCC_CMR_LDB      18
`define TCC_CMR_A_CPA    16
`define TCC_CMR_A_CPC    18
`define TCC_CMR_A_EVT    20
`define TCC_CMR_A_SW     22
`define TCC_CMR_B_CPB    24
`define TCC_CMR_B_CPC    26
`define TCC_CMR_B_EVT    28
`define TCC_CMR_B_SW     30

`define TCC_CCR_CLOCK_ENABLE_COMMAND    0
`define TCC_CCR_CLOCK_DISABLE_COMMAND   1
`define TCC_CCR_SOFTWARE_TRIGGER_COMMAND    2
`define TCC_BCR_SYNC     0
`define TCC_BMR_XC0      0
`define TCC_BMR_XC1      2
`define TCC_BMR_XC2      4

// Status bits
`define TCC_SR_COVFS     0
`define TCC_SR_CPAS      2
`define TCC_SR_CPBS      3
`define TCC_SR_CPCS      4
`define TCC_SR_LDRAS     5
`define TCC_SR_LDRBS     6
`define TCC_SR_ETRGS     7
`define TCC_SR_CLKSTA    16
`define TCC_SR_MTIOA     17
`define TCC_SR_MTIOB     18

// Prescaler taps: bit k toggles with period 2^(k+1)
`define TCC_PRESC_W      10
`define TCC_DIV2_BIT     0
`define TCC_DIV8_BIT     2
`define TCC_DIV32_BIT    4
`define TCC_DIV128_BIT   6
`define TCC_DIV1024_BIT  9

`endif

// ---- rtl/tcc_pkg.sv ----
package tcc_pkg;
  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_SET    = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_TOGGLE = 2'h3
  } tcc_act_e;

  typedef enum logic [1:0] {
    EDGE_NONE  = 2'h0,
    EDGE_RISE  = 2'h1,
    EDGE_FALL  = 2'h2,
    EDGE_BOTH  = 2'h3
  } tcc_edge_e;

  typedef logic [31:0] tcc_word_t;
endpackage

// ---- rtl/tcc_top.sv ----
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_top #(
  parameter int CNT_W = 16
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [2:0]         clock_pin,
  input  wire logic [2:0]         line_a_in,
  output logic      [2:0]         line_a_out,
  output logic      [2:0]         line_a_oe,
  input  wire logic [2:0]         line_b_in,
  output logic      [2:0]         line_b_out,
  output logic      [2:0]         line_b_oe
);

  if (CNT_W < 2 || CNT_W > 32) begin : g_chk
    $error("tcc_top: CNT_W must lie between 2 and 32");
  end

  logic [8:0]                 pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic [`TCC_PRESC_W-1:0]    presc_q;
  logic [5:0]                 bmr_q;
  logic [31:0]                cmr_q    [0:2];
  logic [CNT_W-1:0]           cnt_q    [0:2];
  logic [CNT_W-1:0]           ra_q     [0:2];
  logic [CNT_W-1:0]           rb_q     [0:2];
  logic [CNT_W-1:0]           rc_q     [0:2];
  logic [7:0]                 sr_q     [0:2];
  logic [2:0]                 en_q, run_q, clk_prev_q, trig_prev_q, la_prev_q;
  logic [2:0]                 la_out_q, lb_out_q, la_oe_q, lb_oe_q;
  logic [31:0]                prdata_q;
  logic                       pready_q, pslverr_q;
  logic [2:0]                 clk_pin_f, la_f, lb_f, la_lvl, lb_lvl, xc;
  logic [2:0]                 wave, tick, tick_go, trig_lvl, evt, ext_trg;
  logic [2:0]                 cmpa, cmpb, cmpc, ld_a, ld_b, sw, stop, dis, trig, ovf;
  logic [2:0]                 ccr_wr, sr_rd, clk_eff;
  logic                       acc, wr_acc, sync_pulse;
  logic [31:0]                rd_d;
  logic                       err_d;

  function automatic logic reg_hit(input logic [1:0] ch, input logic [5:0] off);
    reg_hit = (paddr[7:6] == ch) && (paddr[5:0] == off);
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (tcc_pkg::tcc_edge_e'(sel))
      tcc_pkg::EDGE_RISE: edge_hit = cur & ~prev;
      tcc_pkg::EDGE_FALL: edge_hit = ~cur & prev;
      tcc_pkg::EDGE_BOTH: edge_hit = cur ^ prev;
      default:            edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic act_apply(input logic [1:0] act, input logic cur);
    case (tcc_pkg::tcc_act_e'(act))
      tcc_pkg::ACT_SET:    act_apply = 1'b1;
      tcc_pkg::ACT_CLEAR:  act_apply = 1'b0;
      tcc_pkg::ACT_TOGGLE: act_apply = ~cur;
      default:             act_apply = cur;
    endcase
  endfunction

  function automatic logic pick_xc(input logic [1:0] code, input logic [2:0] lines);
    case (code)
      2'h1:    pick_xc = lines[0];
      2'h2:    pick_xc = lines[1];
      2'h3:    pick_xc = lines[2];
      default: pick_xc = 1'b1;
    endcase
  endfunction

  // Pin filter: level moves only once stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_s1_q <= 9'h000;
      pin_s2_q <= 9'h000;
      pin_s3_q <= 9'h000;
      pin_f_q  <= 9'h000;
    end else begin
      pin_s1_q <= {line_b_in, line_a_in, clock_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  assign clk_pin_f = pin_f_q[2:0];
  assign la_f      = pin_f_q[5:3];
  assign lb_f      = pin_f_q[8:6];

  always_ff @(posedge clock) begin
    if (srst) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // APB: one wait state, answer registered
  assign acc        = psel & penable & pready_q;
  assign wr_acc     = acc & pwrite;
  assign sync_pulse = wr_acc & reg_hit(`TCC_BLK_CH, `TCC_OFF_BCR) & pwdata[`TCC_BCR_SYNC];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      wave[i]   = cmr_q[i][`TCC_CMR_WAVE];
      la_lvl[i] = wave[i] ? la_out_q[i] : la_f[i];
      lb_lvl[i] = lb_oe_q[i] ? lb_out_q[i] : lb_f[i];
      ccr_wr[i] = wr_acc & reg_hit(2'(i), `TCC_OFF_CCR);
      sr_rd[i]  = acc & ~pwrite & reg_hit(2'(i), `TCC_OFF_SR);
    end
  end

  // External line routing
  always_comb begin
    case (bmr_q[`TCC_BMR_XC0 +: 2])
      2'h0:    xc[0] = clk_pin_f[0];
      2'h2:    xc[0] = la_lvl[1];
      2'h3:    xc[0] = la_lvl[2];
      default: xc[0] = 1'b0;
    endcase
    case (bmr_q[`TCC_BMR_XC1 +: 2])
      2'h0:    xc[1] = clk_pin_f[1];
      2'h2:    xc[1] = la_lvl[0];
      2'h3:    xc[1] = la_lvl[2];
      default: xc[1] = 1'b0;
    endcase
    case (bmr_q[`TCC_BMR_XC2 +: 2])
      2'h0:    xc[2] = clk_pin_f[2];
      2'h2:    xc[2] = la_lvl[0];
      2'h3:    xc[2] = la_lvl[1];
      default: xc[2] = 1'b0;
    endcase
  end

  // Per-channel event decode
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (cmr_q[i][`TCC_CMR_SRC +: 3])
        3'h0:    clk_eff[i] = presc_q[`TCC_DIV2_BIT];
        3'h1:    clk_eff[i] = presc_q[`TCC_DIV8_BIT];
        3'h2:    clk_eff[i] = presc_q[`TCC_DIV32_BIT];
        3'h3:    clk_eff[i] = presc_q[`TCC_DIV128_BIT];
        3'h4:    clk_eff[i] = presc_q[`TCC_DIV1024_BIT];
        3'h5:    clk_eff[i] = xc[0];
        3'h6:    clk_eff[i] = xc[1];
        default: clk_eff[i] = xc[2];
      endcase
      clk_eff[i] = clk_eff[i] & pick_xc(cmr_q[i][`TCC_CMR_BURST +: 2], xc);
      clk_eff[i] = clk_eff[i] ^ cmr_q[i][`TCC_CMR_CLOCK_INVERT];
      tick[i]    = clk_eff[i] & ~clk_prev_q[i];
      tick_go[i] = tick[i] & en_q[i] & run_q[i];
      if (wave[i]) begin
        case (cmr_q[i][`TCC_CMR_EVSEL +: 2])
          2'h0:    trig_lvl[i] = lb_f[i];
          2'h1:    trig_lvl[i] = xc[0];
          2'h2:    trig_lvl[i] = xc[1];
          default: trig_lvl[i] = xc[2];
        endcase
      end else begin
        trig_lvl[i] = cmr_q[i][`TCC_CMR_TRIGGER_INPUT_SELECT] ? la_f[i] : lb_f[i];
      end
      evt[i]     = edge_hit(cmr_q[i][`TCC_CMR_EDGE +: 2], trig_prev_q[i], trig_lvl[i]);
      ext_trg[i] = evt[i] & (~wave[i] | cmr_q[i][`TCC_CMR_EVENT_TRIGGER_ENABLE]);
      cmpc[i]    = tick_go[i] & (cnt_q[i] == rc_q[i]);
      cmpa[i]    = wave[i] & tick_go[i] & (cnt_q[i] == ra_q[i]);
      cmpb[i]    = wave[i] & tick_go[i] & (cnt_q[i] == rb_q[i]);
      ld_a[i]    = ~wave[i] & edge_hit(cmr_q[i][`TCC_CMR_LDA +: 2], la_prev_q[i], la_f[i]);
      ld_b[i]    = ~wave[i] & edge_hit(cmr_q[i][`TCC_CMR_LDB +: 2], la_prev_q[i], la_f[i]);
      sw[i]      = (ccr_wr[i] & pwdata[`TCC_CCR_SOFTWARE_TRIGGER_COMMAND]) | sync_pulse;
      trig[i]    = sw[i] | ext_trg[i] | (cmpc[i] & cmr_q[i][`TCC_CMR_COMPARE_C_TRIGGER_ENABLE]);
      // Shared bits 6/7 mean load-B or compare-C actions by mode
      stop[i]    = cmr_q[i][`TCC_CMR_STOP] & (wave[i] ? cmpc[i] : ld_b[i]);
      dis[i]     = (ccr_wr[i] & pwdata[`TCC_CCR_CLOCK_DISABLE_COMMAND])
                 | (cmr_q[i][`TCC_CMR_DIS] & (wave[i] ? cmpc[i] : ld_b[i]));
      ovf[i]     = tick_go[i] & (cnt_q[i] == {CNT_W{1'b1}}) & ~trig[i];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      clk_prev_q  <= 3'h0;
      trig_prev_q <= 3'h0;
      la_prev_q   <= 3'h0;
    end else begin
      clk_prev_q  <= clk_eff;
      trig_prev_q <= trig_lvl;
      la_prev_q   <= la_f;
    end
  end

  // Counter; a trigger beats the increment
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        cnt_q[i] <= '0;
      end else if (trig[i]) begin
        cnt_q[i] <= '0;
      end else if (tick_go[i]) begin
        cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end

  // Clock enable and run state
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        en_q[i]  <= 1'b0;
        run_q[i] <= 1'b0;
      end else begin
        if (dis[i]) begin
          en_q[i] <= 1'b0;
        end else if (ccr_wr[i] & pwdata[`TCC_CCR_CLOCK_ENABLE_COMMAND]) begin
          en_q[i] <= 1'b1;
        end
        // Stop wins so a stop-on-compare also ends a compare trigger
        if (stop[i]) begin
          run_q[i] <= 1'b0;
        end else if (trig[i]) begin
          run_q[i] <= 1'b1;
        end
      end
    end
  end

  // Sticky status, set wins over read clear
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        sr_q[i] <= 8'h00;
      end else begin
        sr_q[i] <= (sr_q[i] & ~{8{sr_rd[i]}})
                 | (8'(ovf[i])  << `TCC_SR_COVFS)
                 | (8'(cmpa[i]) << `TCC_SR_CPAS)
                 | (8'(cmpb[i]) << `TCC_SR_CPBS)
                 | (8'(cmpc[i]) << `TCC_SR_CPCS)
                 | (8'(ld_a[i]) << `TCC_SR_LDRAS)
                 | (8'(ld_b[i]) << `TCC_SR_LDRBS)
                 | (8'(evt[i])  << `TCC_SR_ETRGS);
      end
    end
  end

  // Output controller
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        la_out_q[i] <= 1'b0;
        lb_out_q[i] <= 1'b0;
        la_oe_q[i]  <= 1'b0;
        lb_oe_q[i]  <= 1'b0;
      end else begin
        la_oe_q[i] <= wave[i];
        lb_oe_q[i] <= wave[i] & (cmr_q[i][`TCC_CMR_EVSEL +: 2] != 2'h0);
        if (wave[i]) begin
          if (sw[i]) begin
            la_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_A_SW +: 2], la_out_q[i]);
          end else if (evt[i]) begin
            la_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_A_EVT +: 2], la_out_q[i]);
          end else if (cmpc[i]) begin
            la_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_A_CPC +: 2], la_out_q[i]);
          end else if (cmpa[i]) begin
            la_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_A_CPA +: 2], la_out_q[i]);
          end
          if (sw[i]) begin
            lb_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_B_SW +: 2], lb_out_q[i]);
          end else if (evt[i]) begin
            lb_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_B_EVT +: 2], lb_out_q[i]);
          end else if (cmpc[i]) begin
            lb_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_B_CPC +: 2], lb_out_q[i]);
          end else if (cmpb[i]) begin
            lb_out_q[i] <= act_apply(cmr_q[i][`TCC_CMR_B_CPB +: 2], lb_out_q[i]);
          end
        end
      end
    end
  end

  // Mode and value registers; capture loads share A/B with writes
  always_ff @(posedge clock) begin
    if (srst) begin
      bmr_q <= `TCC_BMR_RST;
    end else if (wr_acc & reg_hit(`TCC_BLK_CH, `TCC_OFF_BMR)) begin
      bmr_q <= pwdata[5:0];
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        cmr_q[i] <= `TCC_CMR_RST;
        ra_q[i]  <= '0;
        rb_q[i]  <= '0;
        rc_q[i]  <= '0;
      end else begin
        if (wr_acc & reg_hit(2'(i), `TCC_OFF_CMR)) begin
          cmr_q[i] <= pwdata;
        end
        if (wr_acc & reg_hit(2'(i), `TCC_OFF_RC)) begin
          rc_q[i] <= pwdata[CNT_W-1:0];
        end
        // A and B are software-writable only in waveform mode
        if (ld_a[i]) begin
          ra_q[i] <= cnt_q[i];
        end else if (wave[i] & wr_acc & reg_hit(2'(i), `TCC_OFF_RA)) begin
          ra_q[i] <= pwdata[CNT_W-1:0];
        end
        if (ld_b[i]) begin
          rb_q[i] <= cnt_q[i];
        end else if (wave[i] & wr_acc & reg_hit(2'(i), `TCC_OFF_RB)) begin
          rb_q[i] <= pwdata[CNT_W-1:0];
        end
      end
    end
  end

  always_comb begin
    logic [1:0] ch;
    ch    = paddr[7:6];
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (ch == `TCC_BLK_CH) begin
      case (paddr[5:0])
        `TCC_OFF_BCR: rd_d = 32'h0000_0000;
        `TCC_OFF_BMR: rd_d[5:0] = bmr_q;
        default:      err_d = 1'b1;
      endcase
    end else begin
      case (paddr[5:0])
        `TCC_OFF_CCR: rd_d = 32'h0000_0000;
        `TCC_OFF_CMR: rd_d = cmr_q[ch];
        `TCC_OFF_CVR: rd_d[CNT_W-1:0] = cnt_q[ch];
        `TCC_OFF_RA:  rd_d[CNT_W-1:0] = ra_q[ch];
        `TCC_OFF_RB:  rd_d[CNT_W-1:0] = rb_q[ch];
        `TCC_OFF_RC:  rd_d[CNT_W-1:0] = rc_q[ch];
        `TCC_OFF_SR: begin
          rd_d[7:0]            = sr_q[ch];
          rd_d[`TCC_SR_CLKSTA] = en_q[ch];
          rd_d[`TCC_SR_MTIOA]  = la_lvl[ch];
          rd_d[`TCC_SR_MTIOB]  = lb_lvl[ch];
        end
        default:      err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_d : 32'h0000_0000;
      pslverr_q <= psel & penable & ~pready_q & err_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign line_a_out = la_out_q;
  assign line_a_oe  = la_oe_q;
  assign line_b_out = lb_out_q;
  assign line_b_oe  = lb_oe_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_sync_all_zero: assert property (sync_pulse |=> cnt_q[0] == '0 && cnt_q[1] == '0 && cnt_q[2] == '0)
    else $error("sync write did not zero all counters");
  a_xc_none_low: assert property (bmr_q[`TCC_BMR_XC0 +: 2] == 2'h1 |-> xc[0] == 1'b0)
    else $error("unselected external line not low");
  a_enable_cmd: assert property (ccr_wr[0] && pwdata[`TCC_CCR_CLOCK_ENABLE_COMMAND] && !dis[0] |=> en_q[0])
    else $error("enable command ignored");
  a_disable_cmd: assert property (ccr_wr[0] && pwdata[`TCC_CCR_CLOCK_DISABLE_COMMAND] |=> !en_q[0])
    else $error("disable command ignored");
  a_software_trigger_command_start: assert property (sw[0] && !stop[0] |=> cnt_q[0] == '0 && run_q[0])
    else $error("software trigger did not restart");
  a_count_step: assert property (tick_go[0] && !trig[0] |=> cnt_q[0] == $past(cnt_q[0]) + 1'b1)
    else $error("counter missed an edge");
  a_rc_trigger: assert property (cmpc[0] && cmr_q[0][`TCC_CMR_COMPARE_C_TRIGGER_ENABLE] |=> cnt_q[0] == '0)
    else $error("compare C trigger did not reset");
  a_ldb_stop: assert property (ld_b[0] && cmr_q[0][`TCC_CMR_STOP] |=> !run_q[0] ##1 cnt_q[0] == $past(cnt_q[0]))
    else $error("load B stop did not freeze counter");
  a_ovf_sticky: assert property (ovf[0] |=> sr_q[0][`TCC_SR_COVFS] until sr_rd[0])
    else $error("overflow flag lost before read");
  a_prio_software_trigger_command: assert property (wave[0] && sw[0] && cmr_q[0][`TCC_CMR_A_SW +: 2] == 2'h1 |=> line_a_out[0])
    else $error("software trigger lost priority");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("slave did not answer in one wait state");

  c_sync_write: cover property (sync_pulse);
  c_wave_cmpc:  cover property (wave[0] && cmpc[0]);
  c_capt_loadb: cover property (ld_b[0] ##[1:20] sr_rd[0]);

endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tb;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        ce;
    logic        ee;
  } tcc_row_s;
  logic        clock;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  clock_pin, line_a_in, line_a_out, line_a_oe, line_b_in, line_b_out, line_b_oe;
  logic [31:0] rd;
  logic        er;
  logic        la;
  int          num_errors = 0;
  int          checked    = 0;
  logic [1:0]  codes [5]  = '{2'h1, 2'h0, 2'h3, 2'h3, 2'h2};
  tcc_row_s    rows [13]  = '{
    '{1'h0, 8'hc4, 32'h0, 32'h0, 1'h1, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'h0, 1'h1, 1'h0},
    '{1'h0, 8'h44, 32'h0, 32'h0, 1'h1, 1'h0},
    '{1'h0, 8'h84, 32'h0, 32'h0, 1'h1, 1'h0},
    '{1'h1, 8'hc4, 32'h2d, 32'h0, 1'h1, 1'h0},
    '{1'h0, 8'hc4, 32'h0, 32'h2d, 1'h1, 1'h0},
    '{1'h1, 8'h44, 32'hc5a5_9a5a, 32'h0, 1'h1, 1'h0},
    '{1'h0, 8'h44, 32'h0, 32'hc5a5_9a5a, 1'h1, 1'h0},
    '{1'h1, 8'h44, 32'h0, 32'h0, 1'h1, 1'h0},
    '{1'h0, 8'h00, 32'h0, 32'h0, 1'h0, 1'h0},
    '{1'h0, 8'hc0, 32'h0, 32'h0, 1'h0, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'h0, 1'h1, 1'h1},
    '{1'h1, 8'h0c, 32'hffff_ffff, 32'h0, 1'h1, 1'h1}};
  tcc_top uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_pin(clock_pin),
    .line_a_in(line_a_in), .line_a_out(line_a_out), .line_a_oe(line_a_oe), .line_b_in(line_b_in),
    .line_b_out(line_b_out), .line_b_oe(line_b_oe));
  tcc_pins_model pins (.clock(clock), .line_a_out(line_a_out), .line_a_oe(line_a_oe),
    .line_b_out(line_b_out), .line_b_oe(line_b_oe), .clock_pin(clock_pin), .line_a_in(line_a_in),
    .line_b_in(line_b_in));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
      num_errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic cv(input logic [1:0] ch);
    apb(1'h0, {ch, `TCC_OFF_CVR}, 32'h0);
  endtask
  task automatic srb(input logic [1:0] ch, input int b, input logic e);
    apb(1'h0, {ch, `TCC_OFF_SR}, 32'h0);
    chk({31'h0, rd[b]}, {31'h0, e});
  endtask
  // Outputs may be one register behind the access edge
  task automatic settle;
    repeat (2) @(negedge clock);
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
  initial begin
    srst    <= 1'h1;
    psel    <= 1'h0;
    penable <= 1'h0;
    pwrite  <= 1'h0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    repeat (12) @(posedge clock);
    srst <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(rd, rows[i].e);
      if (rows[i].ce)
        chk({31'h0, er}, {31'h0, rows[i].ee});
    end
    wr(8'h00, 32'h3);
    srb(0, 16, 1'h0);
    wr(8'h00, 32'h1);
    srb(0, 16, 1'h1);
    wr(8'h00, 32'h0);
    srb(0, 16, 1'h1);
    wr(8'h00, 32'h4);
    repeat (20) @(posedge clock);
    cv(0);
    chk({31'h0, rd != 32'h0}, 32'h1);
    wr(8'h00, 32'h2);
    srb(0, 16, 1'h0);
    wr(8'h00, 32'h4);
    cv(0);
    chk(rd, 32'h0);
    for (int c = 0; c < 3; c++)
      wr({c[1:0], 6'h00}, 32'h5);
    repeat (30) @(posedge clock);
    for (int c = 0; c < 3; c++)
      wr({c[1:0], 6'h00}, 32'h2);
    wr(8'hc0, 32'h0);
    cv(0);
    chk({31'h0, rd != 32'h0}, 32'h1);
    wr(8'hc0, 32'h1);
    for (int c = 0; c < 3; c++) begin
      cv(c[1:0]);
      chk(rd, 32'h0);
    end
    wr(8'hc4, 32'h0);
    wr(8'h04, 32'h10);
    wr(8'h00, 32'h5);
    repeat (30) @(posedge clock);
    cv(0);
    chk(rd, 32'h0);
    pins.pulse(1);
    repeat (30) @(posedge clock);
    cv(0);
    chk({31'h0, rd != 32'h0}, 32'h1);
    pins.pulse(1);
    // Seven edges from low: four rising, three falling
    for (int k = 0; k < 3; k++) begin
      wr(8'hc4, k == 2 ? 32'h1 : 32'h0);
      wr(8'h84, k == 1 ? 32'hd : 32'h5);
      wr(8'h80, 32'h5);
      pins.pulse(7);
      repeat (10) @(posedge clock);
      cv(2);
      chk(rd, k == 0 ? 32'h4 : (k == 1 ? 32'h3 : 32'h0));
      pins.pulse(1);
    end
    la = 1'h0;
    foreach (codes[i]) begin
      wr(8'h44, 32'h8400 | {codes[i], 6'h0, codes[i], 22'h0});
      wr(8'h40, 32'h4);
      settle();
      la = codes[i] == 2'h1 ? 1'h1 : (codes[i] == 2'h2 ? 1'h0 : (codes[i] == 2'h3 ? ~la : la));
      chk({30'h0, line_b_out[1], line_a_out[1]}, {30'h0, la, la});
    end
    chk({30'h0, line_b_oe[1], line_a_oe[1]}, 32'h3);
    wr(8'h44, 32'h8000);
    settle();
    chk({30'h0, line_b_oe[1], line_a_oe[1]}, 32'h1);
    wr(8'h44, 32'h0);
    settle();
    chk({30'h0, line_b_oe[1], line_a_oe[1]}, 32'h0);
    wr(8'h1c, 32'h6);
    wr(8'h04, 32'hc000);
    wr(8'h00, 32'h5);
    repeat (4) begin
      repeat (7) @(posedge clock);
      cv(0);
      chk({31'h0, rd <= 32'h6}, 32'h1);
    end
    wr(8'h04, 32'h8000);
    wr(8'h00, 32'h5);
    repeat (40) @(posedge clock);
    cv(0);
    chk({31'h0, rd > 32'h6}, 32'h1);
    wr(8'h04, 32'h8080);
    wr(8'h00, 32'h5);
    repeat (40) @(posedge clock);
    srb(0, 16, 1'h0);
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, 32'h480 | {12'h0, k[1:0], k[1:0], 6'h0, k[1:0], 8'h0});
      wr(8'h00, 32'h5);
      apb(1'h0, 8'h20, 32'h0);
      pins.drive_a(1'h1);
      repeat (10) @(posedge clock);
      apb(1'h0, 8'h20, 32'h0);
      chk({28'h0, rd[16], rd[7:5]}, {28'h0, ~k[0], {3{k[0]}}});
      pins.drive_a(1'h0);
    end
    end_of_test();
  end
endmodule

// ---- verification/tcc_pins_model.sv ----
`timescale 1ns/1ps
module tcc_pins_model (
  input  wire logic       clock,
  input  wire logic [2:0] line_a_out,
  input  wire logic [2:0] line_a_oe,
  input  wire logic [2:0] line_b_out,
  input  wire logic [2:0] line_b_oe,
  output logic      [2:0] clock_pin,
  output logic      [2:0] line_a_in,
  output logic      [2:0] line_b_in
);
  logic [2:0] ext_a = 3'h0;
  // Far side yields each line while the timer drives it
  assign line_a_in = (line_a_oe & line_a_out) | (~line_a_oe & ext_a);
  assign line_b_in = (line_b_oe & line_b_out) | (~line_b_oe & 3'h5);
  initial clock_pin = 3'h0;
  // Slow edges so the pin filter sees every level
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (8) @(posedge clock);
      clock_pin[0] <= ~clock_pin[0];
    end
  endtask
  task automatic drive_a(input logic v);
    @(posedge clock);
    ext_a[0] <= v;
  endtask
endmodule
